// >>> rtl/cpu_supervisor_watchdog.v
`timescale 1ns/1ps
`default_nettype none
`include "cpu_supervisor_watchdog_defs.vh"

// Behaviour
// - Open-drain reset output; polarity fixed by the active-high variant parameter.
// - Reset is asserted while the low-supply detector reports low supply.
// - After supply recovers, reset stays asserted a further 250 ms.
// - At power-up reset is held 250 ms after supply is reported stable.
// - Enabled watchdog asserts reset when data line idles beyond the timeout.
// - Data falling while clock is high restarts the watchdog; host must keep doing so.
// - Restart edges are watched always, regardless of bus traffic or addressing.
// - Timeout picks one of three presets, kept in nonvolatile control storage.
// - Write-protect pin high with protect enable bit set rejects control writes.
// - Array is paged in 64 bytes; a page write takes up to one page.
// - Each nonvolatile write completes by an internally timed cycle of about 5 ms.
// - Protected region: none, quarter, half, all, or top 64/128/256/512 bytes.
module cpu_supervisor_watchdog #(
	parameter ACTIVE_HIGH = 0,
	parameter TICK_CYC = (`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter ARRAY_AW = `ARRAY_AW
) (
	input wire core_clk_i,
	input wire rst_i,
	input wire supply_low_i,
	input wire sda_i,
	input wire scl_i,
	input wire wp_i,
	input wire select_input_0,
	input wire select_input_1,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_wdata_i,
	input wire reg_we_i,
	input wire reg_re_i,
	output reg [31:0] reg_rdata_o,
	output wire rst_out_o,
	output wire rst_out_oe_o
);

	localparam PAGE_AW = `PAGE_AW;
	localparam PAGE_BYTES = `PAGE_BYTES;
	localparam [ARRAY_AW:0] FULL = {1'b1, {ARRAY_AW{1'b0}}};
	localparam [11:0] HOLD_TICKS = `RST_HOLD_MS;
	localparam [11:0] NV_TICKS = `NV_WRITE_MS;
	localparam [11:0] TMO0 = `WD_TMO0_MS;
	localparam [11:0] TMO1 = `WD_TMO1_MS;
	localparam [11:0] TMO2 = `WD_TMO2_MS;
	localparam [31:0] TICK_LAST = TICK_CYC - 1;
	// Bases of the protected regions, counted down from the top of the array.
	localparam [ARRAY_AW:0] BASE_QUARTER = FULL - (FULL >> 2);
	localparam [ARRAY_AW:0] BASE_HALF = FULL >> 1;
	localparam [ARRAY_AW:0] BASE_ALL = {(ARRAY_AW + 1){1'b0}};
	localparam [ARRAY_AW:0] BASE_64 = FULL - {{(ARRAY_AW - 6){1'b0}}, 7'h40};
	localparam [ARRAY_AW:0] BASE_128 = FULL - {{(ARRAY_AW - 7){1'b0}}, 8'h80};
	localparam [ARRAY_AW:0] BASE_256 = FULL - {{(ARRAY_AW - 8){1'b0}}, 9'h100};
	localparam [ARRAY_AW:0] BASE_512 = FULL - {{(ARRAY_AW - 9){1'b0}}, 10'h200};

	// Synchronisers for every pin input.
	reg [5:0] sync1_r;
	reg [5:0] sync2_r;
	reg sda_d_r;
	wire supply_low_s = sync2_r[0];
	wire sda_s = sync2_r[1];
	wire scl_s = sync2_r[2];
	wire wp_s = sync2_r[3];
	// Select pins only feed status; they never gate the restart path.
	wire sel0_s = sync2_r[4];
	wire sel1_s = sync2_r[5];

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			// Stages reset high: the data line looks idle and the supply looks low until seen.
			sync1_r <= 6'h3f;
			sync2_r <= 6'h3f;
			sda_d_r <= 1'b1;
		end else begin
			sync1_r <= {select_input_1, select_input_0, wp_i, scl_i, sda_i, supply_low_i};
			sync2_r <= sync1_r;
			sda_d_r <= sda_s;
		end
	end

	// Restart edge taken straight from the pin path, with no bus gating.
	wire restart = sda_d_r & ~sda_s & scl_s;

	// Internal time base: one enable pulse per tick period.
	// Every slower timer in the block advances only on this pulse.
	// The counter runs from reset, so tick phase is unrelated to any restart edge.
	reg [31:0] tick_cnt_r;
	reg tick_r;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b0;
		end else if (tick_cnt_r >= TICK_LAST) begin
			tick_cnt_r <= 32'h0;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
			tick_r <= 1'b0;
		end
	end

	// Nonvolatile control word and the state around it.
	reg [`CTRL_WIDTH-1:0] ctrl_nv_r;
	reg [`CTRL_WIDTH-1:0] ctrl_pend_r;
	wire wd_en = ctrl_nv_r[`CTRL_WD_EN_BIT];
	wire [1:0] wd_sel = ctrl_nv_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
	wire prot_en = ctrl_nv_r[`CTRL_PEN_BIT];
	wire [2:0] region = ctrl_nv_r[`CTRL_REGION_MSB:`CTRL_REGION_LSB];

	// Watchdog.
	reg [11:0] wd_cnt_r;
	reg [11:0] wd_tmo;
	reg rst_active_r;

	always @* begin
		// Setting 3 repeats the longest preset, so only three intervals exist.
		case (wd_sel)
			2'h0: wd_tmo = TMO0;
			2'h1: wd_tmo = TMO1;
			default: wd_tmo = TMO2;
		endcase
	end

	// Expiry needs one tick past the timeout, so the idle time is never shorter than it.
	wire wd_expire = wd_en & ~rst_active_r & (wd_cnt_r > wd_tmo);
	// The count stops at expiry, so it cannot wrap while the reset it caused is pending.
	// Idle time is counted in whole ticks from the last restart edge.

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wd_cnt_r <= 12'h0;
		end else if (rst_active_r | restart | ~wd_en) begin
			wd_cnt_r <= 12'h0;
		end else if (tick_r & ~wd_expire) begin
			wd_cnt_r <= wd_cnt_r + 12'h1;
		end
	end

	// Reset generator: any cause reloads the hold time.
	// The hold counts whole ticks, so a release lands up to one tick late, never early.
	reg [11:0] hold_r;
	wire rst_cause = supply_low_s | wd_expire;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_active_r <= 1'b1;
			hold_r <= HOLD_TICKS;
		end else if (rst_cause) begin
			rst_active_r <= 1'b1;
			hold_r <= HOLD_TICKS;
		end else if (rst_active_r & tick_r) begin
			if (hold_r == 12'h0) begin
				rst_active_r <= 1'b0;
			end else begin
				hold_r <= hold_r - 12'h1;
			end
		end
	end

	// Open drain only pulls low: low variant pulls while active, high variant while inactive.
	assign rst_out_o = 1'b0;
	assign rst_out_oe_o = (ACTIVE_HIGH != 0) ? ~rst_active_r : rst_active_r;

	// Protected region starts at this byte address and runs to the top of the array.
	reg [ARRAY_AW:0] prot_base;

	always @* begin
		case (region)
			`REGION_NONE: prot_base = FULL;
			`REGION_QUARTER: prot_base = BASE_QUARTER;
			`REGION_HALF: prot_base = BASE_HALF;
			`REGION_ALL: prot_base = BASE_ALL;
			`REGION_64: prot_base = BASE_64;
			`REGION_128: prot_base = BASE_128;
			`REGION_256: prot_base = BASE_256;
			default: prot_base = BASE_512;
		endcase
	end

	// Memory, page buffer and self-timed write.
	reg [7:0] mem [0:(1 << ARRAY_AW) - 1];
	reg [7:0] page_buf [0:PAGE_BYTES-1];
	reg [PAGE_BYTES-1:0] page_mask_r;
	reg [ARRAY_AW-PAGE_AW-1:0] page_r;
	reg [ARRAY_AW-1:0] addr_r;
	reg busy_r;
	reg busy_ctrl_r;
	reg [11:0] busy_cnt_r;
	reg refused_r;
	integer i;

	wire wr_ctrl = reg_we_i & (reg_addr_i == `REG_CTRL);
	wire wr_addr = reg_we_i & (reg_addr_i == `REG_ADDR);
	wire wr_data = reg_we_i & (reg_addr_i == `REG_DATA);
	wire wr_commit = reg_we_i & (reg_addr_i == `REG_COMMIT);
	wire rd_data = reg_re_i & (reg_addr_i == `REG_DATA);
	wire rd_status = reg_re_i & (reg_addr_i == `REG_STATUS);
	// No nonvolatile write starts during a supply dip, so a brown-out cannot corrupt stored state.
	wire nv_block = busy_r | supply_low_s;
	wire ctrl_locked = wp_s & prot_en;
	wire ctrl_ok = wr_ctrl & ~nv_block & ~ctrl_locked;
	wire data_ok = wr_data & ~busy_r;
	wire commit_ok = wr_commit & ~nv_block & (page_mask_r != {PAGE_BYTES{1'b0}});
	// Control writes and page commits share one self-timed cycle; busy refuses both meanwhile.
	wire nv_done = busy_r & tick_r & (busy_cnt_r == 12'h0);
	wire [ARRAY_AW-PAGE_AW-1:0] cur_page = (page_mask_r == {PAGE_BYTES{1'b0}}) ?
		addr_r[ARRAY_AW-1:PAGE_AW] : page_r;

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			busy_r <= 1'b0;
			busy_ctrl_r <= 1'b0;
			busy_cnt_r <= 12'h0;
		end else if (ctrl_ok | commit_ok) begin
			busy_r <= 1'b1;
			busy_ctrl_r <= ctrl_ok;
			busy_cnt_r <= NV_TICKS;
		end else if (nv_done) begin
			busy_r <= 1'b0;
		end else if (busy_r & tick_r) begin
			busy_cnt_r <= busy_cnt_r - 12'h1;
		end
	end

	// Control storage is cleared only by the core reset, never by a supply dip.
	// A new word waits in the pending copy until its write cycle ends.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_nv_r <= `CTRL_RESET;
			ctrl_pend_r <= `CTRL_RESET;
		end else begin
			if (ctrl_ok) begin
				ctrl_pend_r <= reg_wdata_i[`CTRL_WIDTH-1:0];
			end
			if (nv_done & busy_ctrl_r) begin
				ctrl_nv_r <= ctrl_pend_r;
			end
		end
	end

	// A refused control write is reported until status is read; a new refusal wins.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			refused_r <= 1'b0;
		end else if (wr_ctrl & ~ctrl_ok) begin
			refused_r <= 1'b1;
		end else if (rd_status) begin
			refused_r <= 1'b0;
		end
	end

	// Address pointer: data writes wrap inside the page, data reads run on.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			addr_r <= {ARRAY_AW{1'b0}};
		end else if (wr_addr) begin
			addr_r <= reg_wdata_i[ARRAY_AW-1:0];
		end else if (data_ok) begin
			addr_r <= {addr_r[ARRAY_AW-1:PAGE_AW], addr_r[PAGE_AW-1:0] + {{(PAGE_AW-1){1'b0}}, 1'b1}};
		end else if (rd_data) begin
			addr_r <= addr_r + {{(ARRAY_AW-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			page_mask_r <= {PAGE_BYTES{1'b0}};
			page_r <= {(ARRAY_AW-PAGE_AW){1'b0}};
		end else if (nv_done & ~busy_ctrl_r) begin
			page_mask_r <= {PAGE_BYTES{1'b0}};
		end else if (data_ok) begin
			page_r <= cur_page;
			page_mask_r[addr_r[PAGE_AW-1:0]] <= 1'b1;
		end
	end

	always @(posedge core_clk_i) begin
		if (data_ok) begin
			page_buf[addr_r[PAGE_AW-1:0]] <= reg_wdata_i[7:0];
		end
	end

	// One write enable per page byte: buffered, and below the protected region.
	wire [PAGE_BYTES-1:0] byte_we;
	genvar g;

	generate
		for (g = 0; g < PAGE_BYTES; g = g + 1) begin : g_byte
			localparam [PAGE_AW-1:0] OFS = g;
			wire [ARRAY_AW:0] byte_addr = {1'b0, page_r, OFS};
			assign byte_we[g] = page_mask_r[g] & (byte_addr < prot_base);
		end
	endgenerate

	// Commit the buffered page, skipping bytes inside the protected region.
	always @(posedge core_clk_i) begin
		if (nv_done & ~busy_ctrl_r) begin
			for (i = 0; i < PAGE_BYTES; i = i + 1) begin
				if (byte_we[i]) begin
					mem[{page_r, i[PAGE_AW-1:0]}] <= page_buf[i];
				end
			end
		end
	end

	// Status word built field by field, so the bit positions live only in the header.
	reg [31:0] status_word;

	always @* begin
		status_word = 32'h0;
		status_word[`STAT_RST_BIT] = rst_active_r;
		status_word[`STAT_BUSY_BIT] = busy_r;
		status_word[`STAT_REFUSED_BIT] = refused_r;
		status_word[`STAT_WP_BIT] = wp_s;
		status_word[`STAT_SEL0_BIT] = sel0_s;
		status_word[`STAT_SEL1_BIT] = sel1_s;
	end

	// Read port: data stand in the cycle after the strobe only.
	// Unmapped addresses and idle cycles read as zero.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 32'h0;
		end else if (reg_re_i) begin
			case (reg_addr_i)
				`REG_CTRL: reg_rdata_o <= {{(32-`CTRL_WIDTH){1'b0}}, ctrl_nv_r};
				`REG_STATUS: reg_rdata_o <= status_word;
				`REG_ADDR: reg_rdata_o <= {{(32-ARRAY_AW){1'b0}}, addr_r};
				`REG_DATA: reg_rdata_o <= {24'h0, mem[addr_r]};
				default: reg_rdata_o <= 32'h0;
			endcase
		end else begin
			reg_rdata_o <= 32'h0;
		end
	end

endmodule
`default_nettype wire

// >>> rtl/cpu_supervisor_watchdog_defs.vh
`ifndef CPU_SUPERVISOR_WATCHDOG_DEFS_VH
`define CPU_SUPERVISOR_WATCHDOG_DEFS_VH

// Register byte offsets on the plain register port.
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ADDR 8'h08
`define REG_DATA 8'h0c
`define REG_COMMIT 8'h10

// Control register fields.
`define CTRL_WIDTH 7
`define CTRL_WD_EN_BIT 0
`define CTRL_SEL_LSB 1
`define CTRL_SEL_MSB 2
`define CTRL_PEN_BIT 3
`define CTRL_REGION_LSB 4
`define CTRL_REGION_MSB 6
`define CTRL_RESET 7'h01

// Status register fields.
`define STAT_RST_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_REFUSED_BIT 2
`define STAT_WP_BIT 3
`define STAT_SEL0_BIT 4
`define STAT_SEL1_BIT 5

// Protected region codes.
`define REGION_NONE 3'h0
`define REGION_QUARTER 3'h1
`define REGION_HALF 3'h2
`define REGION_ALL 3'h3
`define REGION_64 3'h4
`define REGION_128 3'h5
`define REGION_256 3'h6
`define REGION_512 3'h7

// Timing, in the unit named by each macro.
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000000
`define RST_HOLD_MS 250
`define NV_WRITE_MS 5
`define WD_TMO0_MS 100
`define WD_TMO1_MS 600
`define WD_TMO2_MS 1400

// Memory organisation.
`define PAGE_BYTES 64
`define PAGE_AW 6
`define ARRAY_AW 14

`endif

// >>> rtl/cpu_supervisor_watchdog_defs_check.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> dv/wd_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_supervisor_watchdog_defs.vh"
module wd_monitor #(parameter int TICK_CYC = 10) (
	input wire core_clk_i,
	input wire rst_i,
	input wire supply_low_i,
	input wire sda_i,
	input wire scl_i,
	input wire wp_i,
	input wire reg_re_i,
	input wire [7:0] reg_addr_i,
	input wire [31:0] reg_rdata_o,
	input wire rst_out_o,
	input wire rst_out_oe_o
);
	int low_cnt;
	int act_cnt;
	int idle_cnt;
	logic sda_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// The counters start at the pins, so they never run behind the design's own synchronised view.
	always @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			low_cnt <= 0;
			act_cnt <= 0;
			idle_cnt <= 0;
			sda_q <= 1'b1;
		end else begin
			sda_q <= sda_i;
			low_cnt <= supply_low_i ? 0 : low_cnt + 1;
			act_cnt <= (rst_out_oe_o && !supply_low_i) ? act_cnt + 1 : 0;
			idle_cnt <= (rst_out_oe_o || (sda_q && !sda_i && scl_i)) ? 0 : idle_cnt + 1;
		end
	end
	sequence s_low; supply_low_i [*3]; endsequence
	sequence s_wp; wp_i [*4]; endsequence
	sequence s_rd_stat; reg_re_i && reg_addr_i == `REG_STATUS; endsequence
	a_od_low_only: assert property (rst_out_o == 1'b0)
		else $error("reset pin driven high");
	a_stat_rst_bit: assert property (s_rd_stat |=> reg_rdata_o[0] == $past(rst_out_oe_o))
		else $error("status reset bit differs from pin");
	a_low_forces: assert property (s_low |-> ##[1:2] rst_out_oe_o)
		else $error("low supply without reset");
	a_hold_min: assert property ($fell(rst_out_oe_o) |-> low_cnt >= 250 * TICK_CYC)
		else $error("reset released early");
	a_hold_max: assert property (act_cnt <= 252 * TICK_CYC + 4)
		else $error("reset held too long");
	a_wd_min_idle: assert property ($rose(rst_out_oe_o) && low_cnt > 8 |-> idle_cnt >= 100 * TICK_CYC)
		else $error("watchdog fired too soon");
	a_rd_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0)
		else $error("read data outside its cycle");
	a_wp_status: assert property (s_wp ##0 s_rd_stat |=> reg_rdata_o[`STAT_WP_BIT])
		else $error("protect pin not shown");
endmodule
bind cpu_supervisor_watchdog wd_monitor #(.TICK_CYC(TICK_CYC)) mon_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
	.supply_low_i(supply_low_i), .sda_i(sda_i), .scl_i(scl_i), .wp_i(wp_i), .reg_re_i(reg_re_i),
	.reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .rst_out_o(rst_out_o), .rst_out_oe_o(rst_out_oe_o));
`default_nettype wire

// >>> dv/wd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module wd_host_model (
	input wire logic core_clk_i,
	input wire logic kick_i,
	output logic sda_o,
	output logic scl_o
);
	// Short frames with idle-high lines; the link clock stands still between frames.
	initial begin
		sda_o = 1'b1;
		scl_o = 1'b1;
		forever begin
			@(posedge core_clk_i);
			if (kick_i) begin
				#83 sda_o = 1'b0;
				repeat (4) begin
					#80 scl_o = 1'b0;
					#80 scl_o = 1'b1;
				end
				#80 sda_o = 1'b1;
				repeat (400) @(posedge core_clk_i);
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/cpu_supervisor_watchdog_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cpu_supervisor_watchdog_defs.vh"
`define CHK(nm, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("mismatch %s exp %0h got %0h", nm, e, g); \
	end \
end
module cpu_supervisor_watchdog_tb;
	localparam int TK = 10;
	logic core_clk_i = 1'b0, rst_i = 1'b1, supply_low_i = 1'b0, wp_i = 1'b0;
	logic kick = 1'b0, we = 1'b0, re = 1'b0, sda, scl, od, oe;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	int n_errors = 0, compares = 0, cyc = 0;
	cpu_supervisor_watchdog #(.TICK_CYC(TK)) dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.supply_low_i(supply_low_i), .sda_i(sda), .scl_i(scl), .wp_i(wp_i), .select_input_0(1'b0),
		.select_input_1(1'b1), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
		.reg_rdata_o(rdata), .rst_out_o(od), .rst_out_oe_o(oe));
	wd_host_model host_u (.core_clk_i(core_clk_i), .kick_i(kick), .sda_o(sda), .scl_o(scl));
	always #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge core_clk_i);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		re <= 1'b1;
		@(posedge core_clk_i);
		re <= 1'b0;
		@(posedge core_clk_i);
		d = rdata;
	endtask
	task automatic wait_oe(input logic v, input int lim, output int k);
		k = 0;
		while (oe !== v && k < lim) begin
			@(posedge core_clk_i);
			k++;
		end
	endtask
	task automatic commit_wait(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		int n = 0;
		wr(a, d);
		do begin
			rd(`REG_STATUS, v);
			n++;
		end while (v[`STAT_BUSY_BIT] === 1'b1 && n < 100);
		`CHK("nv_time", 1'b1, n > 22 && n < 33)
	endtask
	task automatic t_powerup();
		int k;
		repeat (2450) @(posedge core_clk_i);
		`CHK("pwr_hold", 1'b1, oe)
		wait_oe(1'b0, 200, k);
		`CHK("pwr_rel", 1'b0, oe)
	endtask
	task automatic t_regs();
		logic [31:0] v;
		rd(`REG_CTRL, v);
		`CHK("ctrl_rst", 32'h01, v)
		rd(`REG_STATUS, v);
		`CHK("status", 32'h20, v)
		`CHK("od_low", 1'b0, od)
		rd(8'h7c, v);
		`CHK("unmapped", 32'h0, v)
	endtask
	task automatic t_mem();
		logic [31:0] v;
		wr(`REG_ADDR, 32'h3fc0);
		@(posedge core_clk_i);
		wr(`REG_DATA, 32'h11);
		commit_wait(`REG_COMMIT, 32'h0);
		commit_wait(`REG_CTRL, 32'h41);
		wr(`REG_ADDR, 32'h007f);
		@(posedge core_clk_i);
		wr(`REG_DATA, 32'h5a);
		@(posedge core_clk_i);
		wr(`REG_DATA, 32'hc3);
		commit_wait(`REG_COMMIT, 32'h0);
		wr(`REG_ADDR, 32'h3fc0);
		@(posedge core_clk_i);
		wr(`REG_DATA, 32'h77);
		commit_wait(`REG_COMMIT, 32'h0);
		wr(`REG_ADDR, 32'h007f);
		rd(`REG_DATA, v);
		`CHK("page_last", 32'h5a, v)
		wr(`REG_ADDR, 32'h0040);
		rd(`REG_DATA, v);
		`CHK("page_wrap", 32'hc3, v)
		wr(`REG_ADDR, 32'h3fc0);
		rd(`REG_DATA, v);
		`CHK("region_kept", 32'h11, v)
		commit_wait(`REG_CTRL, 32'h01);
	endtask
	task automatic t_wd();
		int tmo[3] = '{`WD_TMO0_MS, `WD_TMO1_MS, `WD_TMO2_MS};
		int k;
		for (int s = 0; s < 3; s++) begin
			commit_wait(`REG_CTRL, 32'(1 + 2 * s));
			repeat (1500) @(posedge core_clk_i);
			`CHK("wd_kept", 1'b0, oe)
			kick <= 1'b0;
			wait_oe(1'b1, 15000, k);
			`CHK("wd_fire", 1'b1, k > (tmo[s] + 1) * TK - 460 && k < (tmo[s] + 1) * TK + 20)
			kick <= 1'b1;
			wait_oe(1'b0, 2600, k);
		end
		commit_wait(`REG_CTRL, 32'h0);
		kick <= 1'b0;
		repeat (1600) @(posedge core_clk_i);
		`CHK("wd_off", 1'b0, oe)
		kick <= 1'b1;
		commit_wait(`REG_CTRL, 32'h1);
	endtask
	task automatic t_supply();
		int k;
		supply_low_i <= 1'b1;
		repeat (5) @(posedge core_clk_i);
		`CHK("low_rst", 1'b1, oe)
		supply_low_i <= 1'b0;
		wait_oe(1'b0, 2600, k);
		`CHK("low_hold", 1'b1, k > 2495 && k < 2530)
	endtask
	task automatic t_protect();
		logic [31:0] v;
		commit_wait(`REG_CTRL, 32'h09);
		wp_i <= 1'b1;
		repeat (4) @(posedge core_clk_i);
		wr(`REG_CTRL, 32'h0b);
		rd(`REG_STATUS, v);
		`CHK("refused", 32'h0c, v & 32'h0f)
		rd(`REG_CTRL, v);
		`CHK("ctrl_kept", 32'h09, v)
		wp_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		commit_wait(`REG_CTRL, 32'h01);
		rd(`REG_CTRL, v);
		`CHK("ctrl_new", 32'h01, v)
	endtask
	initial begin
		repeat (12) @(posedge core_clk_i);
		rst_i <= 1'b0;
		kick <= 1'b1;
		t_powerup();
		t_regs();
		t_wd();
		t_supply();
		t_protect();
		t_mem();
		summarize();
	end
endmodule
`default_nettype wire
